// ### bench/ipcs_props.sv
// assertions on the link between channel controller and host agent
`timescale 1ns/1ps
module ipcs_props #(
  parameter int CH = 2
) (
  input logic               clk_sys,
  input logic               rst_n,
  input logic [1:0][CH-1:0] post,
  input logic [1:0][CH-1:0] free,
  input logic [1:0][CH-1:0] occ_mask,
  input logic [1:0][CH-1:0] free_mask,
  input logic [1:0][CH-1:0] mode,
  input logic [1:0][CH-1:0] occ,
  input logic [1:0]         rx_irq,
  input logic [1:0]         tx_irq,
  input logic [1:0]         post_err
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  for (genvar p = 0; p < 2; p++) begin : g_p
    a_rx_level: assert property (rx_irq[p] == $past(|(occ[1-p] & ~occ_mask[p])))
      else $error("rx irq level wrong");
    a_tx_level: assert property (tx_irq[p] == $past(|(~occ[p] & ~free_mask[p] & ~mode[1-p])))
      else $error("tx irq level wrong");
    a_err_cause: assert property (post_err[p] |-> $past(|(post[p] & (occ[p] | mode[1-p]))))
      else $error("refusal without cause");
    c_refused: cover property (post_err[p]);
    c_rx_rise: cover property ($rose(rx_irq[p]));
    c_tx_rise: cover property ($rose(tx_irq[p]));
    for (genvar k = 0; k < CH; k++) begin : g_k
      a_post_sets: assert property (post[p][k] && !occ[p][k] && !mode[1-p][k] |=> occ[p][k])
        else $error("accepted post lost");
      a_post_refused: assert property (post[p][k] && (occ[p][k] || mode[1-p][k]) |=> post_err[p])
        else $error("refusal not flagged");
      a_free_clears: assert property (free[1-p][k] && occ[p][k] |=> !occ[p][k])
        else $error("free not taken");
      a_occ_by_req: assert property (!$stable(occ[p][k]) |-> $past(post[p][k] || free[1-p][k]))
        else $error("flag moved alone");
      a_reserved_stays: assert property (mode[1-p][k] && !occ[p][k] |=> !occ[p][k])
        else $error("reserved channel set");
      // the host must honour the lock itself, so no post may meet a set flag
      a_host_lock: assert property (post[p][k] |-> !occ[p][k])
        else $error("post on held lock");
    end
  end
endmodule // ipcs_props

// ### bench/ipcs_tb.sv
// self-checking bench: host agent and channel controller back to back
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module ipcs_tb
  import ipcs_pkg::*;
();
  localparam int CH = 2;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic [1:0][CH-1:0] post_req = '0, free_req = '0, omask = '1, fmask = '1, mode_cfg = '0;
  logic [1:0][CH-1:0] chan_occupied, tx_occupied, rx_occupied, m_occ = '0;
  logic [1:0]         cpu_rx_irq, cpu_tx_irq, post_evt, free_evt, refuse_evt;
  logic [1:0]         post_busy, rx_irq_seen, tx_irq_seen;
  logic [7:0]         exp_q[$];
  int                 n_mismatch = 0, n_compared = 0, seed = 32'h1f9e;

  ipcs_if #(.CH(CH)) ipcs_if_inst (.clk_sys(clk_sys), .rst_n(rst_n));
  ipcs_ctrl #(.CH(CH)) ipcs_ctrl_inst (.link(ipcs_if_inst), .cpu_rx_irq(cpu_rx_irq),
    .cpu_tx_irq(cpu_tx_irq), .chan_occupied(chan_occupied), .post_evt(post_evt),
    .free_evt(free_evt), .refuse_evt(refuse_evt));
  ipcs_host #(.CH(CH)) ipcs_host_inst (.link(ipcs_if_inst), .post_req(post_req),
    .free_req(free_req), .occ_mask_cfg(omask), .free_mask_cfg(fmask), .mode_cfg(mode_cfg),
    .post_busy(post_busy), .tx_occupied(tx_occupied), .rx_occupied(rx_occupied),
    .rx_irq_seen(rx_irq_seen), .tx_irq_seen(tx_irq_seen));
  ipcs_props #(.CH(CH)) ipcs_props_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .post(ipcs_if_inst.post), .free(ipcs_if_inst.free), .occ_mask(ipcs_if_inst.occ_mask),
    .free_mask(ipcs_if_inst.free_mask), .mode(ipcs_if_inst.mode), .occ(ipcs_if_inst.occ),
    .rx_irq(ipcs_if_inst.rx_irq), .tx_irq(ipcs_if_inst.tx_irq),
    .post_err(ipcs_if_inst.post_err));

  always #10 clk_sys = ~clk_sys;

  // note layout: post_evt, free_evt, refuse_evt, post_busy, two bits each
  function automatic logic [7:0] ev(input int sh, input int p);
    return 8'h01 << (sh + p);
  endfunction

  // pulses are flop outputs, settled by the falling edge
  always @(negedge clk_sys) begin
    logic [7:0] got;
    got = {post_evt, free_evt, refuse_evt, post_busy};
    if (rst_n === 1'b1 && (|got) !== 1'b0) begin
      `CHK(got, (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00)
    end
  end

  task automatic req(input bit fr, input int p, input logic [1:0] ks, input logic [7:0] note);
    @(negedge clk_sys);
    if (fr) free_req[p] = ks;
    else post_req[p] = ks;
    if (note !== 8'h00) exp_q.push_back(note);
    @(negedge clk_sys);
    free_req = '0;
    post_req = '0;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic chk();
    logic [1:0] erx, etx;
    for (int q = 0; q < 2; q++) begin
      erx[q] = |(m_occ[1-q] & ~omask[q]);
      etx[q] = |(~m_occ[q] & ~fmask[q] & ~mode_cfg[1-q]);
    end
    `CHK(cpu_rx_irq, erx)
    `CHK(cpu_tx_irq, etx)
    `CHK(rx_irq_seen, erx)
    `CHK(tx_irq_seen, etx)
    `CHK(chan_occupied, m_occ)
    `CHK(tx_occupied, m_occ)
    `CHK(rx_occupied, {m_occ[0], m_occ[1]})
  endtask

  task automatic end_of_test();
    `CHK(exp_q.size(), 0)
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    int p, k;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 12; i++) begin
      p = i % 2;
      k = (i / 2) % 2;
      if (i >= 4) begin
        omask = 4'($random(seed));
        fmask = 4'($random(seed));
      end
      repeat (4) @(negedge clk_sys);
      chk();
      req(1'b0, p, 2'(1 << k), ev(6, p));
      m_occ[p][k] = 1'b1;
      chk();
      req(1'b0, p, 2'(1 << k), ev(0, p));
      req(1'b1, 1 - p, 2'(1 << k), ev(4, 1 - p));
      m_occ[p][k] = 1'b0;
      chk();
    end
    req(1'b1, 0, 2'b11, 8'h00);
    req(1'b0, 0, 2'b11, ev(6, 0));
    m_occ[0] = 2'b11;
    chk();
    req(1'b1, 1, 2'b11, ev(4, 1));
    m_occ[0] = 2'b00;
    omask = '0;
    fmask = '0;
    mode_cfg[0][0] = IPCS_HALF_DUPLEX;
    repeat (4) @(negedge clk_sys);
    chk();
    req(1'b0, 1, 2'b01, ev(2, 1));
    req(1'b0, 0, 2'b01, ev(6, 0));
    m_occ[0][0] = 1'b1;
    chk();
    req(1'b1, 1, 2'b01, ev(4, 1));
    m_occ[0][0] = 1'b0;
    chk();
    end_of_test();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end
endmodule // ipcs_tb

// ### rtl/ipcs_consts.svh
// size and reset constants of the inter-processor channel signaling block
`ifndef IPCS_CONSTS_SVH
`define IPCS_CONSTS_SVH

`define IPCS_NUM_PROC   2
`define IPCS_CH_PER_DIR 2
`define IPCS_CH_MAX     16
`define IPCS_OCC_RST    1'b0
`define IPCS_MASK_RST   1'b1
`define IPCS_MODE_RST   1'b0
`define IPCS_IRQ_RST    1'b0
`define IPCS_EVT_RST    1'b0

`endif

// ### rtl/ipcs_ctrl.sv
// channel controller: occupied flags, refusal and interrupt lines of both processors
`timescale 1ns/1ps
`include "ipcs_consts.svh"

// Behaviour
// - two outgoing channels per processor, four total
// - single-cycle atomic post and free, never blocking
// - one occupied flag per channel, acts as lock
// - receive line per processor on incoming occupied
// - transmit line per processor on outgoing freed
// - separate occupied and free masks per channel
// - simplex: each channel its own one-way slot
// - half duplex: one channel, shared two-way slot
// - payload lives in shared memory, not here
module ipcs_ctrl
  import ipcs_pkg::*;
#(
  parameter int CH = `IPCS_CH_PER_DIR
) (
  ipcs_if.ctrl                 link,
  output logic [1:0]           cpu_rx_irq,
  output logic [1:0]           cpu_tx_irq,
  output logic [1:0][CH-1:0]   chan_occupied,
  output logic [1:0]           post_evt,
  output logic [1:0]           free_evt,
  output logic [1:0]           refuse_evt
);

  localparam int NPROC = `IPCS_NUM_PROC;

  // refused at elaboration: flag vectors and masks are sized for 1 to 16
  if (CH < 1 || CH > `IPCS_CH_MAX) begin : g_bad_ch
    $error("ipcs_ctrl: channel count per direction out of range");
  end

  // the peer of p is 1-p, so the controller serves exactly one pair
  if (NPROC != 2) begin : g_bad_proc
    $error("ipcs_ctrl: exactly two processors are supported");
  end

  // a post is turned away on a held lock or on a channel taken by half duplex
  function automatic logic ipcs_post_blocked(input logic held, input logic taken);
    return held | taken;
  endfunction

  // a channel is taken while the reverse slot of its pair runs half duplex
  function automatic logic ipcs_slot_taken(input logic peer_mode);
    return ipcs_mode_t'(peer_mode) == IPCS_HALF_DUPLEX;
  endfunction

  // occ[p][k]: channel k carrying posts from processor p to its peer
  logic [1:0][CH-1:0] occ;
  logic [1:0][CH-1:0] next_occ;
  logic [1:0][CH-1:0] post_ok;
  logic [1:0][CH-1:0] free_ok;
  logic [1:0][CH-1:0] reserved;

  logic [1:0]         rx_irq;
  logic [1:0]         tx_irq;
  logic [1:0]         next_rx_irq;
  logic [1:0]         next_tx_irq;
  // per-channel hits, or-ed into one level per processor
  logic [1:0][CH-1:0] rx_hit;
  logic [1:0][CH-1:0] tx_hit;

  logic [1:0]         post_err;
  logic [1:0]         next_post_err;
  logic [1:0]         post_pulse;
  logic [1:0]         free_pulse;
  logic [1:0]         next_post_pulse;
  logic [1:0]         next_free_pulse;

  // the payload is never seen here; only flags move through this block

  // a channel whose peer slot is half duplex is taken by that exchange:
  // replies travel in the same memory slot, so the reverse channel is idle
  always_comb begin
    reserved = '0;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < CH; k++) begin
        if (ipcs_slot_taken(link.mode[ipcs_peer(p)][k])) begin
          reserved[p][k] = 1'b1;
        end else begin
          reserved[p][k] = 1'b0;
        end
      end
    end
  end

  // one update per channel per cycle; both requests resolve in the same edge
  generate
    for (genvar gp = 0; gp < 2; gp++) begin : g_proc
      for (genvar gk = 0; gk < CH; gk++) begin : g_chan
        always_comb begin
          post_ok[gp][gk] = link.post[gp][gk] &
                            ~ipcs_post_blocked(occ[gp][gk], reserved[gp][gk]);
          free_ok[gp][gk] = link.free[1-gp][gk] & occ[gp][gk];
          // a post needs the flag clear and a free needs it set, so the two never
          // meet; should that change, the set is placed first and wins
          if (post_ok[gp][gk]) begin
            next_occ[gp][gk] = 1'b1;
          end else if (free_ok[gp][gk]) begin
            next_occ[gp][gk] = 1'b0;
          end else begin
            next_occ[gp][gk] = occ[gp][gk];
          end
        end
      end
    end
  endgenerate

  // simplex channels stand alone, each steered only by its own flag

  // after reset every flag reads free to both sides
  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      occ <= {2*CH{`IPCS_OCC_RST}};
    end else begin
      occ <= next_occ;
    end
  end

  // refusals: post on a held lock or on a channel reserved by half duplex
  // only the refusing processor hears of it; the flag is left alone
  always_comb begin
    next_post_err = '0;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < CH; k++) begin
        if (link.post[p][k] && ipcs_post_blocked(occ[p][k], reserved[p][k])) begin
          next_post_err[p] = 1'b1;
        end
      end
    end
  end

  // interrupt levels follow the registered flags, one cycle behind them
  // free channels that are masked or reserved stay quiet on the transmit line
  always_comb begin
    rx_hit      = '0;
    tx_hit      = '0;
    next_rx_irq = '0;
    next_tx_irq = '0;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < CH; k++) begin
        rx_hit[p][k] = occ[ipcs_peer(p)][k] & ~link.occ_mask[p][k];
        tx_hit[p][k] = ~occ[p][k] & ~link.free_mask[p][k] & ~reserved[p][k];
      end
      next_rx_irq[p] = |rx_hit[p];
      next_tx_irq[p] = |tx_hit[p];
    end
  end

  // masks only gate the line; the flag itself is never touched by them
  // a level, not a pulse, so a late-unmasked pending channel still raises it

  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      rx_irq <= {2{`IPCS_IRQ_RST}};
      tx_irq <= {2{`IPCS_IRQ_RST}};
    end else begin
      rx_irq <= next_rx_irq;
      tx_irq <= next_tx_irq;
    end
  end

  // one-cycle event pulses for tracing on the user side
  // a free by p clears flags on the peer's outgoing channels
  always_comb begin
    next_post_pulse = '0;
    next_free_pulse = '0;
    for (int p = 0; p < 2; p++) begin
      next_post_pulse[p] = |post_ok[p];
      next_free_pulse[p] = |free_ok[ipcs_peer(p)];
    end
  end

  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      post_err   <= {2{`IPCS_EVT_RST}};
      post_pulse <= {2{`IPCS_EVT_RST}};
      free_pulse <= {2{`IPCS_EVT_RST}};
    end else begin
      post_err   <= next_post_err;
      post_pulse <= next_post_pulse;
      free_pulse <= next_free_pulse;
    end
  end

  // link and user copies come from the same flops, so both sides see one value
  assign link.occ      = occ;
  assign link.rx_irq   = rx_irq;
  assign link.tx_irq   = tx_irq;
  assign link.post_err = post_err;

  assign cpu_rx_irq    = rx_irq;
  assign cpu_tx_irq    = tx_irq;
  assign chan_occupied = occ;
  assign post_evt      = post_pulse;
  assign free_evt      = free_pulse;
  assign refuse_evt    = post_err;

endmodule // ipcs_ctrl

// ### rtl/ipcs_host.sv
// processors' bus agent: lock-respecting posts and frees, mask and mode config
`timescale 1ns/1ps
`include "ipcs_consts.svh"

module ipcs_host
  import ipcs_pkg::*;
#(
  parameter int CH = `IPCS_CH_PER_DIR
) (
  ipcs_if.host                 link,
  input  logic [1:0][CH-1:0]   post_req,
  input  logic [1:0][CH-1:0]   free_req,
  input  logic [1:0][CH-1:0]   occ_mask_cfg,
  input  logic [1:0][CH-1:0]   free_mask_cfg,
  input  logic [1:0][CH-1:0]   mode_cfg,
  output logic [1:0]           post_busy,
  output logic [1:0][CH-1:0]   tx_occupied,
  output logic [1:0][CH-1:0]   rx_occupied,
  output logic [1:0]           rx_irq_seen,
  output logic [1:0]           tx_irq_seen
);

  if (CH < 1 || CH > `IPCS_CH_MAX) begin : g_bad_ch
    $error("ipcs_host: channel count per direction out of range");
  end

  logic [1:0][CH-1:0] post;
  logic [1:0][CH-1:0] free;
  logic [1:0][CH-1:0] occ_mask;
  logic [1:0][CH-1:0] free_mask;
  logic [1:0][CH-1:0] mode;
  logic [1:0][CH-1:0] next_post;
  logic [1:0][CH-1:0] next_free;
  logic [1:0][CH-1:0] tx_view;
  logic [1:0][CH-1:0] rx_view;
  logic [1:0][CH-1:0] next_rx_view;
  logic [1:0]         busy;
  logic [1:0]         next_busy;
  logic [1:0]         rx_seen;
  logic [1:0]         tx_seen;

  // the flag lags a post by one cycle, so a post still in flight counts as held
  always_comb begin
    next_busy    = '0;
    next_rx_view = '0;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < CH; k++) begin
        next_post[p][k] = post_req[p][k] & ~link.occ[p][k] & ~post[p][k];
        next_free[p][k] = free_req[p][k] & link.occ[ipcs_peer(p)][k] & ~free[p][k];
        next_rx_view[p][k] = link.occ[ipcs_peer(p)][k];
        if (post_req[p][k] && (link.occ[p][k] || post[p][k])) begin
          next_busy[p] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      post      <= '0;
      free      <= '0;
      occ_mask  <= {2*CH{`IPCS_MASK_RST}};
      free_mask <= {2*CH{`IPCS_MASK_RST}};
      mode      <= {2*CH{`IPCS_MODE_RST}};
      busy      <= '0;
      tx_view   <= {2*CH{`IPCS_OCC_RST}};
      rx_view   <= {2*CH{`IPCS_OCC_RST}};
      rx_seen   <= {2{`IPCS_IRQ_RST}};
      tx_seen   <= {2{`IPCS_IRQ_RST}};
    end else begin
      post      <= next_post;
      free      <= next_free;
      occ_mask  <= occ_mask_cfg;
      free_mask <= free_mask_cfg;
      mode      <= mode_cfg;
      busy      <= next_busy;
      tx_view   <= link.occ;
      rx_view   <= next_rx_view;
      rx_seen   <= link.rx_irq;
      tx_seen   <= link.tx_irq;
    end
  end

  // only flags cross the link; payload stays in the shared memory slot
  assign link.post      = post;
  assign link.free      = free;
  assign link.occ_mask  = occ_mask;
  assign link.free_mask = free_mask;
  assign link.mode      = mode;

  assign post_busy   = busy;
  assign tx_occupied = tx_view;
  assign rx_occupied = rx_view;
  assign rx_irq_seen = rx_seen;
  assign tx_irq_seen = tx_seen;

endmodule // ipcs_host

// ### rtl/ipcs_if.sv
// interface joining the channel controller and the processors' bus agent
`timescale 1ns/1ps
interface ipcs_if #(
  parameter int CH = 2
) (
  input logic clk_sys,
  input logic rst_n
);
  logic [1:0][CH-1:0] post;
  logic [1:0][CH-1:0] free;
  logic [1:0][CH-1:0] occ_mask;
  logic [1:0][CH-1:0] free_mask;
  logic [1:0][CH-1:0] mode;
  logic [1:0][CH-1:0] occ;
  logic [1:0]         rx_irq;
  logic [1:0]         tx_irq;
  logic [1:0]         post_err;

  modport ctrl (
    input  clk_sys,
    input  rst_n,
    input  post,
    input  free,
    input  occ_mask,
    input  free_mask,
    input  mode,
    output occ,
    output rx_irq,
    output tx_irq,
    output post_err
  );

  modport host (
    input  clk_sys,
    input  rst_n,
    output post,
    output free,
    output occ_mask,
    output free_mask,
    output mode,
    input  occ,
    input  rx_irq,
    input  tx_irq,
    input  post_err
  );
endinterface

// ### rtl/ipcs_pkg.sv
// types shared by both ends of the inter-processor channel signaling block
package ipcs_pkg;

  typedef enum logic {
    IPCS_SIMPLEX     = 1'b0,
    IPCS_HALF_DUPLEX = 1'b1
  } ipcs_mode_t;

  // processor index of the party on the far side of a channel
  function automatic int ipcs_peer(input int p);
    return 1 - p;
  endfunction

endpackage
